// [rtl/uet_top.sv]
`timescale 1ns/1ns
`default_nettype none
module uet_top (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Serial pins
  output logic             tx_o,
  output logic             tx_oe_o,
  output logic             rx_pin_sel_o,
  // Interrupt request
  output logic             irq_o
);
  import uet_pkg::*;

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    UET_IDLE   = 5'b00001,
    UET_START  = 5'b00010,
    UET_DATA   = 5'b00100,
    UET_PARITY = 5'b01000,
    UET_STOP   = 5'b10000
  } uet_state_t;

  uet_state_t  state;          // Transmit sequencer
  uet_state_t  next_state;     // Next sequencer state
  logic [7:0]  ctrl_one;       // control_reg_one
  logic [7:0]  ctrl_two;       // control_reg_two
  logic [7:0]  baud_div;       // baud_divisor
  logic [7:0]  data_buf;       // data_buffer_reg holding
  logic        buf_full;       // Buffer holds a word
  logic        tx_idle_flag;   // Frame complete flag
  logic        status_armed;   // Status read seen
  logic [8:0]  transmit_shift_register;            // transmit_shift_register
  logic [3:0]  bit_cnt;        // Data bits sent
  logic        stop_cnt;       // Stop bits sent
  logic        par_bit;        // Parity for this frame
  uet_fmt_t    fmt;            // Format of current frame
  logic [5:0]  presc;          // Baud prescaler
  logic [7:0]  baud_cnt;       // Baud divisor counter
  logic [31:0] rdata;          // Read data register

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire         uart_enable   = ctrl_one[UET_C1_UART_ENABLE];
  wire         tx_enable     = ctrl_two[UET_C2_TX_ENABLE];
  wire         rx_enable     = ctrl_two[UET_C2_RX_ENABLE];
  wire         tx_buffer_empty_flag = ~buf_full;
  wire         setup_ph      = psel_i & ~penable_i;
  wire         access_ph     = psel_i & penable_i;
  wire         hit_c1        = paddr_i == UET_ADDR_CTRL_ONE;
  wire         hit_c2        = paddr_i == UET_ADDR_CTRL_TWO;
  wire         hit_st        = paddr_i == UET_ADDR_STATUS;
  wire         hit_dt        = paddr_i == UET_ADDR_DATA;
  wire         hit_bd        = paddr_i == UET_ADDR_BAUD;
  wire         hit_any       = hit_c1 | hit_c2 | hit_st | hit_dt | hit_bd;
  wire         wr_c1         = access_ph & pwrite_i & hit_c1;
  wire         wr_c2         = access_ph & pwrite_i & hit_c2;
  wire         wr_bd         = access_ph & pwrite_i & hit_bd;
  wire         wr_dt         = access_ph & pwrite_i & hit_dt;
  wire         rd_st         = access_ph & ~pwrite_i & hit_st;
  // Write accepted only after a status read and while empty
  wire         wr_accept     = wr_dt & status_armed & tx_buffer_empty_flag & uart_enable;
  wire         tx_run        = uart_enable & tx_enable;
  wire         is_idle       = state == UET_IDLE;
  // Load shifter from idle: direct write or waiting buffer
  wire         load_idle     = tx_run & is_idle & (wr_accept | buf_full);
  wire [7:0]   load_byte     = buf_full ? data_buf : pwdata_i[7:0];

  // Baud tick: (N+1) steps of 16 or 64 clocks
  wire [5:0]   presc_lim     = ctrl_two[UET_C2_BAUD_HIGH] ? UET_PRESC_HIGH : UET_PRESC_LOW;
  wire         presc_end     = presc == presc_lim;
  wire         tick          = presc_end & (baud_cnt == baud_div);

  // Format from control_reg_one
  wire         word9         = ctrl_one[UET_C1_WORD_LENGTH];
  wire [3:0]   word_bits     = word9 ? UET_BITS_9 : UET_BITS_8;
  // Parity takes the place of the last bit
  wire [3:0]   word_bits_f   = fmt.word9 ? UET_BITS_9 : UET_BITS_8;
  wire [3:0]   data_bits     = fmt.par_en ? word_bits_f - 4'h1 : word_bits_f;
  // Ninth bit is the MSB, taken from UET_C1_TX_NINTH and sent only when the word length is 9
  wire [8:0]   load_word     = {ctrl_one[UET_C1_TX_NINTH] & word9, load_byte};
  wire         par_en_now    = ctrl_one[UET_C1_PARITY_EN];
  wire [3:0]   load_dbits    = par_en_now ? word_bits - 4'h1 : word_bits;
  wire         last_data     = bit_cnt == data_bits - 4'h1;
  wire         frame_done    = tick & (state == UET_STOP) & (stop_cnt | ~fmt.two_stop);
  wire         load_next     = frame_done & buf_full & tx_run;
  wire         load_any      = load_idle | load_next;

  // Parity over the data bits actually sent
  logic [8:0]  par_mask;
  logic        load_par;
  always_comb begin
    par_mask = 9'h000;
    for (int i = 0; i < 9; i++) begin
      par_mask[i] = 4'(i) < load_dbits;
    end
    load_par = (^(load_word & par_mask)) ^ ctrl_one[UET_C1_PARITY_TYPE];
  end

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  // Next state, one bit per tick
  always_comb begin
    next_state = state;
    unique case (state)
      UET_IDLE: begin
        if (load_idle) begin
          next_state = UET_START;
        end
      end
      UET_START: begin
        if (tick) begin
          next_state = UET_DATA;
        end
      end
      UET_DATA: begin
        if (tick & last_data) begin
          next_state = fmt.par_en ? UET_PARITY : UET_STOP;
        end
      end
      UET_PARITY: begin
        if (tick) begin
          next_state = UET_STOP;
        end
      end
      UET_STOP: begin
        if (frame_done) begin
          next_state = load_next ? UET_START : UET_IDLE;
        end
      end
      default: begin
        next_state = UET_IDLE;
      end
    endcase
  end

  // Sequencer register; enables off abort at once
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= UET_IDLE;
    end else if (!tx_run) begin
      state <= UET_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Shifter, counters and captured format
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      transmit_shift_register      <= 9'h000;
      bit_cnt  <= 4'h0;
      stop_cnt <= 1'b0;
      par_bit  <= 1'b0;
      fmt      <= '0;
    end else if (load_any) begin
      // Capture word and format together
      transmit_shift_register      <= load_next ? {ctrl_one[UET_C1_TX_NINTH] & word9, data_buf} : load_word;
      bit_cnt  <= 4'h0;
      stop_cnt <= 1'b0;
      par_bit  <= load_par;
      fmt      <= '{word9, par_en_now, ctrl_one[UET_C1_PARITY_TYPE], ctrl_one[UET_C1_STOP_COUNT]};
    end else if (tick) begin
      if (state == UET_DATA) begin
        transmit_shift_register     <= {1'b0, transmit_shift_register[8:1]};
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (state == UET_STOP) begin
        stop_cnt <= 1'b1;
      end
    end
  end

  // Line level, registered
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_o <= 1'b1;
    end else if (!tx_run) begin
      // Abort lifts the line on the next clock, not after the sequencer
      tx_o <= 1'b1;
    end else begin
      unique case (state)
        UET_START:  tx_o <= 1'b0;
        UET_DATA:   tx_o <= transmit_shift_register[0];
        UET_PARITY: tx_o <= par_bit;
        default:    tx_o <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  // Restarts on a load from idle so the start bit is whole
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc    <= 6'h00;
      baud_cnt <= 8'h00;
    end else if (!uart_enable | load_idle) begin
      presc    <= 6'h00;
      baud_cnt <= 8'h00;
    end else if (presc_end) begin
      presc    <= 6'h00;
      baud_cnt <= tick ? 8'h00 : baud_cnt + 8'h01;
    end else begin
      presc    <= presc + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Data buffer and flags
  // ----------------------------------------------------------------
  // Buffer fill and drain
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf_full <= 1'b0;
      data_buf <= 8'h00;
    end else if (!uart_enable) begin
      buf_full <= 1'b0;
    end else if (wr_accept & ~load_idle) begin
      buf_full <= 1'b1;
      data_buf <= pwdata_i[7:0];
    end else if (load_any) begin
      buf_full <= 1'b0;
    end
  end

  // Idle flag: frame end sets, accepted write clears, set wins
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_idle_flag <= 1'b1;
    end else if (!uart_enable) begin
      tx_idle_flag <= 1'b1;
    end else if (frame_done) begin
      tx_idle_flag <= 1'b1;
    end else if (wr_accept) begin
      tx_idle_flag <= 1'b0;
    end
  end

  // Status read arms the clearing write
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_armed <= 1'b0;
    end else if (rd_st) begin
      status_armed <= 1'b1;
    end else if (wr_dt | !uart_enable) begin
      status_armed <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Disable clears only enables and break; rest kept
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_one <= UET_CTRL_ONE_RST;
      ctrl_two <= UET_CTRL_TWO_RST;
      baud_div <= UET_BAUD_RST;
    end else begin
      if (wr_c1) begin
        ctrl_one <= pwdata_i[7:0];
      end
      if (wr_bd) begin
        baud_div <= pwdata_i[7:0];
      end
      if (!uart_enable) begin
        ctrl_two[UET_C2_TX_ENABLE]  <= 1'b0;
        ctrl_two[UET_C2_RX_ENABLE]  <= 1'b0;
        ctrl_two[UET_C2_SEND_BREAK] <= 1'b0;
        if (wr_c2) begin
          ctrl_two[UET_C2_BAUD_HIGH]   <= pwdata_i[UET_C2_BAUD_HIGH];
          ctrl_two[UET_C2_ADDR_DETECT] <= pwdata_i[UET_C2_ADDR_DETECT];
          ctrl_two[UET_C2_TX_EMPTY_IE] <= pwdata_i[UET_C2_TX_EMPTY_IE];
        end
      end else if (wr_c2) begin
        ctrl_two <= pwdata_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB read data
  // ----------------------------------------------------------------
  // Receive flags stay cleared; receive idle stays set
  wire [7:0] status_val = {5'h00, 1'b1, tx_idle_flag, tx_buffer_empty_flag};
  wire [7:0] rd_mux     = hit_c1 ? ctrl_one :
                          hit_c2 ? ctrl_two :
                          hit_st ? status_val :
                          hit_bd ? baud_div : 8'h00;

  // Read data captured in the setup cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata <= 32'h0000_0000;
    end else if (setup_ph & ~pwrite_i) begin
      rdata <= {24'h000000, rd_mux};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o     = rdata;
  assign pready_o     = 1'b1;
  assign pslverr_o    = access_ph & ~hit_any;
  assign tx_oe_o      = tx_run;
  assign rx_pin_sel_o = uart_enable & rx_enable;
  assign irq_o        = uart_enable & tx_buffer_empty_flag & ctrl_two[UET_C2_TX_EMPTY_IE];
endmodule
`default_nettype wire

// [common/uet_pkg.sv]
`default_nettype none
package uet_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] UET_ADDR_CTRL_ONE = 8'h00; // control_reg_one
  localparam logic [7:0] UET_ADDR_CTRL_TWO = 8'h04; // control_reg_two
  localparam logic [7:0] UET_ADDR_STATUS   = 8'h08; // status_register
  localparam logic [7:0] UET_ADDR_DATA     = 8'h0C; // data_buffer_reg
  localparam logic [7:0] UET_ADDR_BAUD     = 8'h10; // baud_divisor

  // ----------------------------------------------------------------
  // control_reg_one fields
  // ----------------------------------------------------------------
  localparam int UET_C1_UART_ENABLE = 7;
  localparam int UET_C1_WORD_LENGTH = 6;
  localparam int UET_C1_PARITY_EN   = 5;
  localparam int UET_C1_PARITY_TYPE = 4;
  localparam int UET_C1_STOP_COUNT  = 3;
  localparam int UET_C1_TX_NINTH    = 0;
  // control_reg_two fields
  localparam int UET_C2_TX_ENABLE   = 7;
  localparam int UET_C2_RX_ENABLE   = 6;
  localparam int UET_C2_BAUD_HIGH   = 5;
  localparam int UET_C2_ADDR_DETECT = 4;
  localparam int UET_C2_SEND_BREAK  = 3;
  localparam int UET_C2_TX_EMPTY_IE = 0;
  // status_register fields
  localparam int UET_ST_TX_BUF_EMPTY = 0;
  localparam int UET_ST_TX_IDLE      = 1;
  localparam int UET_ST_RX_IDLE      = 2;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] UET_CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] UET_CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] UET_BAUD_RST     = 8'h00;
  localparam logic [5:0] UET_PRESC_LOW    = 6'h3F; // 64 clocks per step
  localparam logic [5:0] UET_PRESC_HIGH   = 6'h0F; // 16 clocks per step
  localparam logic [3:0] UET_BITS_8       = 4'h8;
  localparam logic [3:0] UET_BITS_9       = 4'h9;

  // Frame format captured at load time
  typedef struct packed {
    logic       word9;
    logic       par_en;
    logic       par_odd;
    logic       two_stop;
  } uet_fmt_t;
endpackage
`default_nettype wire

// [bench/uet_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module uet_checker (
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  // Bus side
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Pin side
  input wire logic        tx_o,
  input wire logic        tx_oe_o,
  input wire logic        rx_pin_sel_o,
  input wire logic        irq_o
);
  import uet_pkg::*;
  // ----
  // Shadow state
  // ----
  logic [7:0] c1;   // Copy of control_reg_one
  logic [7:0] c2;   // Copy of control_reg_two
  logic [7:0] baud; // Copy of the divisor
  int         low;  // Cycles of the current low run
  int         per;  // Bit period in clocks
  logic       wr;   // Write access phase
  assign wr  = psel_i & penable_i & pwrite_i;
  assign per = (int'(baud) + 1) * (c2[5] ? 16 : 64);
  // Follow writes; enables drop while disabled
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c1   <= 8'h00;
      c2   <= 8'h00;
      baud <= 8'h00;
      low  <= 0;
    end else begin
      low <= tx_o ? 0 : low + 1;
      if (wr && paddr_i == UET_ADDR_CTRL_ONE) begin
        c1 <= pwdata_i[7:0];
        if (!pwdata_i[7]) begin
          c2 <= c2 & 8'h37;
        end
      end
      if (wr && paddr_i == UET_ADDR_CTRL_TWO) begin
        c2 <= c1[7] ? pwdata_i[7:0] : pwdata_i[7:0] & 8'h37;
      end
      if (wr && paddr_i == UET_ADDR_BAUD) begin
        baud <= pwdata_i[7:0];
      end
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  a_tx_pin_owner: assert property (tx_oe_o == (c1[7] & c2[7]))
    else $error("tx drive enable off its enables");
  a_rx_pin_owner: assert property (rx_pin_sel_o == (c1[7] & c2[6]))
    else $error("rx select off its enables");
  a_pins_released: assert property (!c1[7] |-> !tx_oe_o && !rx_pin_sel_o)
    else $error("pins kept while disabled");
  a_released_high: assert property (!tx_oe_o && !$past(tx_oe_o) |-> tx_o)
    else $error("released line not high");
  a_abort_high: assert property ($fell(tx_oe_o) |=> tx_o)
    else $error("line not high after abort");
  a_high_bit_len: assert property ($rose(tx_o) && tx_oe_o |-> tx_o [*8])
    else $error("high level shorter than a bit");
  a_low_whole_bits: assert property ($rose(tx_o) && tx_oe_o |-> low % per == 0)
    else $error("low run not whole bits");
  a_low_run_bound: assert property (low <= 10 * per)
    else $error("low run longer than a frame");
  a_irq_gated: assert property (irq_o |-> c1[7] && c2[0])
    else $error("interrupt without enables");
  c_abort: cover property ($fell(tx_oe_o));
  c_nine_bit: cover property ($rose(tx_o) && tx_oe_o && c1[6]);
  c_irq: cover property (irq_o);
endmodule
bind uet_top uet_checker uet_checker_i (.clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tx_o, .tx_oe_o, .rx_pin_sel_o, .irq_o);
`default_nettype wire

// [bench/uet_serial_peer.sv]
`timescale 1ns/1ns
`default_nettype none
module uet_serial_peer (
  // Clock
  input  wire logic        clk_i,
  // Line and format
  input  wire logic        line_i,
  input  wire logic [15:0] period_i,
  input  wire logic [3:0]  bits_i,
  // Capture
  output var logic [11:0]  word_o,
  output var logic [7:0]   frames_o
);
  // ----
  // Receiver
  // ----
  initial begin
    word_o = 12'hFFF;
    frames_o = 8'h00;
  end
  // Falling edge opens a frame; sample mid-bit, LSB first
  always begin
    @(negedge line_i);
    repeat (period_i / 2) @(posedge clk_i);
    word_o = 12'hFFF;
    for (int k = 0; k <= int'(bits_i); k++) begin
      word_o[k] = line_i;
      if (k < int'(bits_i)) begin
        repeat (period_i) @(posedge clk_i);
      end
    end
    frames_o = frames_o + 8'h01;
  end
endmodule
`default_nettype wire

// [bench/test_uart_enable_and_transmitter.sv]
`timescale 1ns/1ns
`default_nettype none
module test_uart_enable_and_transmitter;
  import uet_pkg::*;
  // ----
  // Signals
  // ----
  typedef struct packed {
    logic [7:0] c1; // Format, enable set
    logic [7:0] d;  // Byte sent
    logic [7:0] st; // Status after frame
  } uet_row_t;
  uet_row_t    rows [6] = '{'{8'h80, 8'h55, 8'h07}, '{8'hA8, 8'hA3, 8'h07}, '{8'hB0, 8'h0F, 8'h07},
                            '{8'hC1, 8'h80, 8'h07}, '{8'hF9, 8'h3C, 8'h07}, '{8'hC0, 8'hFF, 8'h07}};
  logic        clk = 1'b0, rst_n = 1'b0;         // Clock, reset
  logic        psel = 1'b0, penable = 1'b0;      // Bus phase
  logic        pwrite = 1'b0;                    // Bus direction
  logic [7:0]  paddr = 8'h00;                    // Bus address
  logic [31:0] pwdata = 32'h0, prdata, r;        // Bus data
  logic        pready, pslverr, e;               // Bus answer
  logic        tx, tx_oe, rx_sel, irq, line;     // Pins
  logic [3:0]  nbits = 4'h9;                     // Bits after start
  logic [11:0] word;                             // Captured frame
  logic [7:0]  frames;                           // Frame count
  logic [15:0] f;                                // Expected frame
  int          n0, cycles = 0;                   // Marks
  int          miscompares = 0, cmp_count = 0;   // Tallies
  assign line = tx_oe ? tx : 1'b1; // Pull-up when released
  uet_top uet_top_i (.clk_sys_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .tx_o(tx), .tx_oe_o(tx_oe), .rx_pin_sel_o(rx_sel), .irq_o(irq));
  uet_serial_peer uet_serial_peer_i (.clk_i(clk), .line_i(line), .period_i(16'h0010),
    .bits_i(nbits), .word_o(word), .frames_o(frames));
  always #50 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] bit32(input logic v);
    return {31'h0, v};
  endfunction
  // Count after start, then expected line bits
  function automatic logic [15:0] frame_of(input logic [7:0] c1, input logic [7:0] d);
    logic [8:0]  v;
    logic [11:0] w;
    int          n;
    v = {c1[0], d};
    n = (c1[6] ? 9 : 8) - int'(c1[5]);
    w = 12'hFFE;
    for (int k = 0; k < n; k++) w[k + 1] = v[k];
    if (c1[5]) w[n + 1] = (^(v & ((9'h001 << n) - 9'h001))) ^ c1[4];
    return {4'(n + 1 + int'(c1[5]) + int'(c1[3])), w};
  endfunction
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d);
    apb(1'b0, UET_ADDR_STATUS, 32'h0);
    apb(1'b1, UET_ADDR_DATA, {24'h0, d});
  endtask
  task automatic wait_frame(input int n, input int extra);
    int t;
    t = 0;
    while (int'(frames) != n && t < 4000) begin
      @(posedge clk);
      t++;
    end
    chk("frames", 32'(n), {24'h0, frames});
    repeat (extra) @(posedge clk);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("tx", 32'h1, bit32(tx));
    chk("tx_oe", 32'h0, bit32(tx_oe));
    apb(1'b0, UET_ADDR_STATUS, 32'h0);
    chk("status", 32'h7, r);
    apb(1'b0, 8'h14, 32'h0);
    chk("pslverr", 32'h1, bit32(e));
    apb(1'b1, UET_ADDR_CTRL_ONE, 32'h80);
    apb(1'b1, UET_ADDR_CTRL_TWO, 32'hE1);
    apb(1'b1, UET_ADDR_BAUD, 32'h0);
    @(posedge clk);
    chk("rx_sel", 32'h1, bit32(rx_sel));
    chk("irq", 32'h1, bit32(irq));
    foreach (rows[i]) begin
      apb(1'b1, UET_ADDR_CTRL_ONE, {24'h0, rows[i].c1});
      f = frame_of(rows[i].c1, rows[i].d);
      nbits = f[15:12];
      n0 = int'(frames);
      send(rows[i].d);
      wait_frame(n0 + 1, 24);
      chk("word", {20'h0, f[11:0]}, {20'h0, word});
      apb(1'b0, UET_ADDR_STATUS, 32'h0);
      chk("status", {24'h0, rows[i].st}, r);
    end
    // Direct send, refused writes, buffered send
    apb(1'b1, UET_ADDR_CTRL_ONE, 32'h80);
    f = frame_of(8'h80, 8'h3C);
    nbits = f[15:12];
    n0 = int'(frames);
    send(8'h3C);
    apb(1'b1, UET_ADDR_DATA, 32'hAA);
    apb(1'b0, UET_ADDR_STATUS, 32'h0);
    chk("status", 32'h5, r);
    apb(1'b1, UET_ADDR_DATA, 32'h96);
    apb(1'b0, UET_ADDR_STATUS, 32'h0);
    chk("status", 32'h4, r);
    chk("irq", 32'h0, bit32(irq));
    apb(1'b1, UET_ADDR_DATA, 32'h69);
    wait_frame(n0 + 1, 0);
    chk("word", {20'h0, f[11:0]}, {20'h0, word});
    f = frame_of(8'h80, 8'h96);
    wait_frame(n0 + 2, 0);
    chk("word", {20'h0, f[11:0]}, {20'h0, word});
    repeat (400) @(posedge clk);
    chk("frames", n0 + 2, {24'h0, frames});
    // Disable in mid-frame with data buffered
    send(8'h81);
    send(8'h42);
    repeat (40) @(posedge clk);
    apb(1'b1, UET_ADDR_CTRL_ONE, 32'h0);
    repeat (2) @(posedge clk);
    chk("tx", 32'h1, bit32(tx));
    chk("tx_oe", 32'h0, bit32(tx_oe));
    apb(1'b0, UET_ADDR_STATUS, 32'h0);
    chk("status", 32'h7, r);
    apb(1'b0, UET_ADDR_CTRL_TWO, 32'h0);
    chk("ctrl2", 32'h21, r);
    repeat (200) @(posedge clk);
    n0 = int'(frames);
    apb(1'b1, UET_ADDR_CTRL_ONE, 32'h80);
    apb(1'b1, UET_ADDR_CTRL_TWO, 32'hA1);
    repeat (400) @(posedge clk);
    chk("frames", n0, {24'h0, frames});
    // Data loaded before the transmitter is on
    apb(1'b1, UET_ADDR_CTRL_TWO, 32'h21);
    f = frame_of(8'h80, 8'hE7);
    send(8'hE7);
    repeat (40) @(posedge clk);
    chk("frames", n0, {24'h0, frames});
    apb(1'b1, UET_ADDR_CTRL_TWO, 32'hA1);
    wait_frame(n0 + 1, 0);
    chk("word", {20'h0, f[11:0]}, {20'h0, word});
    // Transmit enable cleared in mid-frame
    send(8'h18);
    repeat (40) @(posedge clk);
    apb(1'b1, UET_ADDR_CTRL_TWO, 32'h21);
    repeat (2) @(posedge clk);
    chk("tx", 32'h1, bit32(tx));
    chk("tx_oe", 32'h0, bit32(tx_oe));
    close_out();
  end
endmodule
`default_nettype wire
